// ### rtl/base_period_tick.sv
// Purpose: Produces one pulse per 2.78 us base period from mclk.
// Assumes: mclk at 250 MHz.
// Notes: Count held in reset while disabled, so the first tick is a full period late.
`timescale 1ns/1ps
`include "integ_timing_regs.svh"
module base_period_tick #(
	parameter int CYCLES = (`BASE_PERIOD_PS + `CLK_PERIOD_PS / 2) / `CLK_PERIOD_PS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Control
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(CYCLES + 1);
	initial begin
		if (CYCLES < 1) $error("base_period_tick: CYCLES must be at least 1");
	end
	logic [W-1:0] count;
	wire last = (count == W'(CYCLES - 1));
	always_ff @(posedge mclk) begin
		if (reset || !run || last) count <= '0;
		else count <= count + W'(1);
	end
	always_ff @(posedge mclk) begin
		if (reset) tick <= 1'b0;
		else tick <= run && last;
	end
endmodule

// ### rtl/integ_timing_pkg.sv
// Purpose: Types shared by the integration timing block.
// Assumes: Constants live in integ_timing_regs.svh.
// Notes: One-hot state codes are written out.
package integ_timing_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_INTEGRATE = 3'b010,
		ST_DONE = 3'b100
	} integ_state_t;
endpackage

// ### rtl/integ_timing_regs.svh
// Purpose: Register offsets, field positions, reset values and timing constants.
// Assumes: 8-bit register port, byte offsets as printed.
// Notes: The main enable register and the spare control/status registers are local choices.
`ifndef INTEG_TIMING_REGS_SVH
`define INTEG_TIMING_REGS_SVH

`define ADDR_MAIN_ENABLE 8'h80
`define ADDR_STEP_COUNT 8'h81
`define ADDR_STEP_SIZE_LO 8'hD4
`define ADDR_STEP_SIZE_HI 8'hD5
`define ADDR_IRQ_ENABLES 8'hF9
`define ADDR_CONTROL 8'hFA
`define ADDR_ENGINE_STATUS 8'hF0
`define ADDR_FULL_SCALE_LO 8'hF1
`define ADDR_FULL_SCALE_HI 8'hF2

`define BIT_POWER_ON 0
`define BIT_MEAS_ENABLE 1
`define BIT_MAIN_SPECTRAL_IRQ_ENABLE 6

`define BIT_SAT_IEN 7
`define BIT_SPECTRAL_IRQ_ENABLE 3
`define BIT_FIFO_IEN 2
`define BIT_SYS_IEN 0

`define BIT_SOFTWARE_RESET_REQUEST 3
`define BIT_MAN_AZ 2
`define BIT_FIFO_FLUSH 1
`define BIT_SAI_RELEASE 0

`define RST_STEP_COUNT 8'h00
`define RST_STEP_SIZE 16'h03E7
`define RST_BYTE 8'h00
`define FULL_SCALE_MAX 17'h0FFFF
`define BASE_PERIOD_PS 2780000
`define CLK_PERIOD_PS 4000

`endif

// ### rtl/integration_timing_and_control.sv
// Purpose: Interrupt enables, control actions and integration time / full-scale logic.
// Assumes: 8-bit register port, one-cycle strobes, read data one cycle later.
// Notes: Engine events come in on mclk; the engines themselves sit outside.
`timescale 1ns/1ps
`include "integ_timing_regs.svh"
module integration_timing_and_control
	import integ_timing_pkg::*;
#(
	parameter int COUNT_W = 8,
	parameter int SIZE_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Raw events from the engines
	input wire logic saturation_event,
	input wire logic spectral_threshold_hit,
	input wire logic persistence_met,
	input wire logic fifo_above_threshold,
	input wire logic flicker_status_changed,
	input wire logic sensor_mux_config_done,
	// Gated interrupt requests
	output logic saturation_irq,
	output logic spectral_irq,
	output logic fifo_irq,
	output logic system_irq,
	// Actions to the engines, and sleep_after_irq_flag back from them
	output logic power_on_reset_request,
	output logic autozero_start,
	output logic fifo_flush,
	output logic sleep_after_irq_release,
	input wire logic sleep_after_irq_flag,
	// Measurement timing
	output logic measurement_enable,
	output logic integrating,
	output logic integration_done,
	output logic [15:0] full_scale
);
	initial begin
		if (COUNT_W != 8 || SIZE_W != 16) $error("register widths are fixed at 8 and 16");
	end

	logic [7:0] main_enable;
	logic [COUNT_W-1:0] integration_step_count;
	logic [SIZE_W-1:0] integration_step_size;
	logic [7:0] interrupt_enables;
	logic [3:0] action_pulse;
	logic [COUNT_W-1:0] step_index;
	logic [SIZE_W-1:0] base_index;
	integ_state_t state;
	integ_state_t next_state;
	logic tick;

	localparam int PW = COUNT_W + SIZE_W + 2;

	// Multiply with saturation to the 16-bit ADC range; operands widened first
	function automatic logic [15:0] clamp_full_scale(input logic [COUNT_W-1:0] c,
			input logic [SIZE_W-1:0] s);
		logic [PW-1:0] prod;
		prod = (PW'(c) + PW'(1)) * (PW'(s) + PW'(1));
		if (prod > PW'(`FULL_SCALE_MAX)) clamp_full_scale = 16'hFFFF;
		else clamp_full_scale = prod[15:0];
	endfunction

	// Address decode
	wire hit_main = (reg_addr == `ADDR_MAIN_ENABLE);
	wire hit_count = (reg_addr == `ADDR_STEP_COUNT);
	wire hit_size_lo = (reg_addr == `ADDR_STEP_SIZE_LO);
	wire hit_size_hi = (reg_addr == `ADDR_STEP_SIZE_HI);
	wire hit_ien = (reg_addr == `ADDR_IRQ_ENABLES);
	wire hit_ctrl = (reg_addr == `ADDR_CONTROL);
	wire hit_status = (reg_addr == `ADDR_ENGINE_STATUS);
	wire hit_fs_lo = (reg_addr == `ADDR_FULL_SCALE_LO);
	wire hit_fs_hi = (reg_addr == `ADDR_FULL_SCALE_HI);

	wire spectral_irq_enable = interrupt_enables[`BIT_SPECTRAL_IRQ_ENABLE];
	wire power_on = main_enable[`BIT_POWER_ON];
	wire [7:0] main_view = {main_enable[7], spectral_irq_enable, main_enable[5:0]};
	wire [7:0] status_view = {5'h00, sleep_after_irq_flag, state == ST_DONE,
		state == ST_INTEGRATE};
	wire [15:0] next_full_scale = clamp_full_scale(integration_step_count,
		integration_step_size);

	wire [7:0] read_mux =
		hit_main ? main_view :
		hit_count ? integration_step_count :
		hit_size_lo ? integration_step_size[7:0] :
		hit_size_hi ? integration_step_size[15:8] :
		hit_ien ? interrupt_enables :
		hit_ctrl ? 8'h00 :
		hit_status ? status_view :
		hit_fs_lo ? full_scale[7:0] :
		hit_fs_hi ? full_scale[15:8] : 8'h00;

	// Writes; a software reset returns every register to its reset value
	always_ff @(posedge mclk) begin
		if (reset || action_pulse[`BIT_SOFTWARE_RESET_REQUEST]) begin
			main_enable <= `RST_BYTE;
			integration_step_count <= `RST_STEP_COUNT;
			integration_step_size <= `RST_STEP_SIZE;
			interrupt_enables <= `RST_BYTE;
		end else if (reg_write) begin
			if (hit_main) main_enable <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
			if (hit_main) interrupt_enables[`BIT_SPECTRAL_IRQ_ENABLE] <= reg_wdata[`BIT_MAIN_SPECTRAL_IRQ_ENABLE];
			if (hit_count) integration_step_count <= reg_wdata;
			if (hit_size_lo) integration_step_size[7:0] <= reg_wdata;
			if (hit_size_hi) integration_step_size[15:8] <= reg_wdata;
			if (hit_ien) interrupt_enables <= {reg_wdata[7], 3'h0, reg_wdata[3:2], 1'b0,
				reg_wdata[0]};
		end
	end

	// Control actions are one-cycle pulses, never stored
	always_ff @(posedge mclk) begin
		if (reset) action_pulse <= 4'h0;
		else if (reg_write && hit_ctrl) action_pulse <= reg_wdata[3:0];
		else action_pulse <= 4'h0;
	end

	always_ff @(posedge mclk) begin
		if (reset) reg_rdata <= 8'h00;
		else if (reg_read) reg_rdata <= read_mux;
		else reg_rdata <= 8'h00;
	end

	assign power_on_reset_request = action_pulse[`BIT_SOFTWARE_RESET_REQUEST];
	assign autozero_start = action_pulse[`BIT_MAN_AZ];
	assign fifo_flush = action_pulse[`BIT_FIFO_FLUSH];
	assign sleep_after_irq_release = action_pulse[`BIT_SAI_RELEASE];
	assign measurement_enable = power_on && main_enable[`BIT_MEAS_ENABLE];

	// Interrupt gating
	always_ff @(posedge mclk) begin
		if (reset) begin
			saturation_irq <= 1'b0;
			spectral_irq <= 1'b0;
			fifo_irq <= 1'b0;
			system_irq <= 1'b0;
		end else begin
			saturation_irq <= interrupt_enables[`BIT_SAT_IEN] && saturation_event;
			spectral_irq <= spectral_irq_enable && spectral_threshold_hit && persistence_met;
			fifo_irq <= interrupt_enables[`BIT_FIFO_IEN] && fifo_above_threshold
				&& !fifo_flush;
			system_irq <= interrupt_enables[`BIT_SYS_IEN]
				&& (flicker_status_changed || sensor_mux_config_done);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) full_scale <= 16'h0000;
		else full_scale <= next_full_scale;
	end

	// Integration sequencer: counts base periods per step, steps per integration
	base_period_tick u_tick (
		.mclk(mclk),
		.reset(reset),
		.run(state == ST_INTEGRATE),
		.tick(tick)
	);

	wire last_base = (base_index == integration_step_size);
	wire last_step = (step_index == integration_step_count);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (measurement_enable && !sleep_after_irq_flag) next_state = ST_INTEGRATE;
			end
			ST_INTEGRATE: begin
				if (!measurement_enable) next_state = ST_IDLE;
				else if (tick && last_base && last_step) next_state = ST_DONE;
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset || action_pulse[`BIT_SOFTWARE_RESET_REQUEST]) state <= ST_IDLE;
		else state <= next_state;
	end

	always_ff @(posedge mclk) begin
		if (reset || state != ST_INTEGRATE) begin
			base_index <= '0;
			step_index <= '0;
		end else if (tick) begin
			if (last_base) begin
				base_index <= '0;
				step_index <= step_index + COUNT_W'(1);
			end else begin
				base_index <= base_index + SIZE_W'(1);
			end
		end
	end

	assign integrating = (state == ST_INTEGRATE);
	assign integration_done = (state == ST_DONE);
endmodule

// ### tb/host_model.sv
// Purpose: Host side of the register port.
// Assumes: Strobes one cycle, read data in the cycle after.
// Notes: Signals change only right after a rising edge.
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule

// ### tb/integ_timing_assertions.sv
// Purpose: Port-level checks of interrupt gating and control pulses.
// Assumes: One clock, synchronous reset.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`include "integ_timing_regs.svh"
module integ_timing_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// Events
	input wire logic saturation_event,
	input wire logic spectral_threshold_hit,
	input wire logic persistence_met,
	input wire logic fifo_above_threshold,
	input wire logic flicker_status_changed,
	input wire logic sensor_mux_config_done,
	// Requests
	input wire logic saturation_irq,
	input wire logic spectral_irq,
	input wire logic fifo_irq,
	input wire logic system_irq,
	input wire logic power_on_reset_request,
	input wire logic autozero_start,
	input wire logic fifo_flush,
	input wire logic sleep_after_irq_release
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire ctl_wr = reg_write && reg_addr == `ADDR_CONTROL;
	sat_gate_a: assert property (saturation_irq |-> $past(saturation_event))
		else $error("saturation request without event");
	spec_gate_a: assert property (spectral_irq |->
		$past(spectral_threshold_hit && persistence_met))
		else $error("spectral request without threshold and persistence");
	fifo_gate_a: assert property (fifo_irq |->
		$past(fifo_above_threshold && !fifo_flush))
		else $error("fifo request without level or during flush");
	sys_gate_a: assert property (system_irq |->
		$past(flicker_status_changed || sensor_mux_config_done))
		else $error("system request without event");
	software_reset_request_a: assert property (ctl_wr && reg_wdata[`BIT_SOFTWARE_RESET_REQUEST] |=> power_on_reset_request)
		else $error("software reset not issued");
	autozero_cause_a: assert property (autozero_start |-> $past(ctl_wr && reg_wdata[`BIT_MAN_AZ]))
		else $error("autozero without control write");
	flush_pulse_a: assert property (ctl_wr && reg_wdata[`BIT_FIFO_FLUSH] |=> fifo_flush)
		else $error("flush not issued");
	sleep_release_a: assert property (sleep_after_irq_release |->
		$past(ctl_wr && reg_wdata[`BIT_SAI_RELEASE]))
		else $error("sleep release without control write");
	ctl_reads_zero_a: assert property (reg_read && reg_addr == `ADDR_CONTROL |=> reg_rdata == 8'h00)
		else $error("control register read not zero");
endmodule
bind integration_timing_and_control integ_timing_assertions chk (
	.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.saturation_event(saturation_event), .spectral_threshold_hit(spectral_threshold_hit),
	.persistence_met(persistence_met), .fifo_above_threshold(fifo_above_threshold),
	.flicker_status_changed(flicker_status_changed),
	.sensor_mux_config_done(sensor_mux_config_done), .saturation_irq(saturation_irq),
	.spectral_irq(spectral_irq), .fifo_irq(fifo_irq), .system_irq(system_irq),
	.power_on_reset_request(power_on_reset_request), .autozero_start(autozero_start),
	.fifo_flush(fifo_flush), .sleep_after_irq_release(sleep_after_irq_release)
);

// ### tb/tb.sv
// Purpose: Self-checking bench for the integration timing block.
// Assumes: Default base period of 695 cycles.
// Notes: Each scenario judges its own results.
`timescale 1ns/1ps
`include "integ_timing_regs.svh"
module tb;
	logic mclk = 0, reset = 1, sat = 0, thr = 0, pers = 0, fab = 0, flk = 0, mux = 0;
	logic sleep = 0, s_irq, p_irq, f_irq, y_irq, por, az, flush, rel, meas, integ, done;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_write, reg_read;
	logic [15:0] full_scale;
	int error_cnt = 0, checked = 0;
	logic [7:0] cnt_tab [4] = '{8'h00, 8'h01, 8'h01, 8'hFF};
	logic [15:0] size_tab [4] = '{16'h0001, 16'h7FFE, 16'h7FFF, 16'h00FF};
	initial forever #2 mclk = ~mclk;
	host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	integration_timing_and_control dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .saturation_event(sat), .spectral_threshold_hit(thr),
		.persistence_met(pers), .fifo_above_threshold(fab), .flicker_status_changed(flk),
		.sensor_mux_config_done(mux), .saturation_irq(s_irq), .spectral_irq(p_irq),
		.fifo_irq(f_irq), .system_irq(y_irq), .power_on_reset_request(por),
		.autozero_start(az), .fifo_flush(flush), .sleep_after_irq_release(rel),
		.sleep_after_irq_flag(sleep), .measurement_enable(meas), .integrating(integ),
		.integration_done(done), .full_scale(full_scale));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_reset;
		host.rd(`ADDR_STEP_COUNT, d);
		check(d, 16'h0000);
		host.rd(`ADDR_STEP_SIZE_LO, d);
		check(d, 16'h00E7);
		host.rd(`ADDR_STEP_SIZE_HI, d);
		check(d, 16'h0003);
		check(full_scale, 16'h03E8);
		host.wr(8'h10, 8'hFF);
		host.rd(8'h10, d);
		check(d, 16'h0000);
	endtask
	task t_irq;
		host.wr(`ADDR_IRQ_ENABLES, 8'hFF);
		host.rd(`ADDR_IRQ_ENABLES, d);
		check(d, 16'h008D);
		host.rd(`ADDR_MAIN_ENABLE, d);
		check(d, 16'h0040);
		@(posedge mclk) {sat, thr, pers, fab, flk} <= 5'h1F;
		repeat (2) @(posedge mclk);
		#1 check({s_irq, p_irq, f_irq, y_irq}, 16'h000F);
		@(posedge mclk) {pers, flk, mux} <= 3'b001;
		repeat (2) @(posedge mclk);
		#1 check({p_irq, y_irq}, 16'h0001);
		host.wr(`ADDR_IRQ_ENABLES, 8'h00);
		repeat (2) @(posedge mclk);
		#1 check({s_irq, p_irq, f_irq, y_irq}, 16'h0000);
	endtask
	task t_scale;
		int p;
		for (int i = 0; i < 4; i++) begin
			host.wr(`ADDR_STEP_COUNT, cnt_tab[i]);
			host.wr(`ADDR_STEP_SIZE_LO, size_tab[i][7:0]);
			host.wr(`ADDR_STEP_SIZE_HI, size_tab[i][15:8]);
			repeat (2) @(posedge mclk);
			p = (int'(cnt_tab[i]) + 1) * (int'(size_tab[i]) + 1);
			#1 check(full_scale, p > 65535 ? 16'hFFFF : p[15:0]);
			host.rd(`ADDR_FULL_SCALE_LO, d);
			check(d, p > 65535 ? 16'h00FF : 16'(p[7:0]));
		end
	endtask
	task t_ctl;
		host.wr(`ADDR_MAIN_ENABLE, 8'h01);
		host.wr(`ADDR_CONTROL, 8'h02);
		#1 check(flush, 16'h0001);
		@(posedge mclk);
		#1 check(flush, 16'h0000);
		host.wr(`ADDR_CONTROL, 8'h05);
		#1 check({az, rel, flush}, 16'h0006);
		host.rd(`ADDR_CONTROL, d);
		check(d, 16'h0000);
		host.wr(`ADDR_STEP_COUNT, 8'h55);
		host.wr(`ADDR_CONTROL, 8'h08);
		#1 check(por, 16'h0001);
		repeat (2) @(posedge mclk);
		host.rd(`ADDR_STEP_COUNT, d);
		check(d, 16'h0000);
	endtask
	task t_integ;
		int n;
		host.wr(`ADDR_MAIN_ENABLE, 8'h01);
		host.wr(`ADDR_STEP_SIZE_LO, 8'h01);
		host.wr(`ADDR_STEP_SIZE_HI, 8'h00);
		host.wr(`ADDR_MAIN_ENABLE, 8'h03);
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			#1 n++;
		end
		check(16'(n >= 1388 && n <= 1396), 16'h0001);
		host.wr(`ADDR_MAIN_ENABLE, 8'h01);
		repeat (3) @(posedge mclk);
		#1 check({meas, integ}, 16'h0000);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		t_reset;
		t_irq;
		t_scale;
		t_ctl;
		t_integ;
		end_of_test;
	end
	initial begin
		#40000;
		error_cnt++;
		end_of_test;
	end
endmodule
